// ---- gpio_bank_pkg.sv ----
// Constants for the GPIO bank block: register offsets, config field layout,
// reset values and per-pin capability masks.
// Assumes pins 0-3 are bank four bits 0-3, 4-11 bank five, 12-13 bank six.
`default_nettype none
package gpio_bank_pkg;
   // ****************************************
   // Sizes
   // ****************************************
   localparam int NUM_PINS = 14;
   localparam int NUM_SAMP = 16;
   localparam int TACH_ONE_IDX = 14;
   localparam int TACH_TWO_IDX = 15;

   // ****************************************
   // Configuration port indices
   // ****************************************
   localparam logic [7:0] BASE_LO_INDEX = 8'h60;
   localparam logic [7:0] BASE_HI_INDEX = 8'h61;
   localparam logic [15:0] BASE_RESET = 16'h0000;

   // ****************************************
   // Runtime block offsets
   // ****************************************
   localparam logic [7:0] OFS_DATA_BANK4 = 8'h4E;
   localparam logic [7:0] OFS_DATA_BANK5 = 8'h4F;
   localparam logic [7:0] OFS_DATA_BANK6 = 8'h50;
   localparam logic [7:0] OFS_CFG_FIRST = 8'h30;
   localparam logic [7:0] OFS_GLOBAL_WAKE = 8'h01;
   localparam logic [7:0] OFS_WAKE_STS4 = 8'h0A;
   localparam logic [7:0] OFS_WAKE_STS5 = 8'h0B;
   localparam logic [7:0] OFS_WAKE_EN4 = 8'h0E;
   localparam logic [7:0] OFS_WAKE_EN5 = 8'h0F;
   localparam logic [7:0] OFS_MISC_STS = 8'h12;
   localparam logic [7:0] OFS_MGMT_STS3 = 8'h16;
   localparam logic [7:0] OFS_MGMT_STS4 = 8'h17;
   localparam logic [7:0] OFS_MGMT_STS5 = 8'h18;
   localparam logic [7:0] OFS_MGMT_EN3 = 8'h1A;
   localparam logic [7:0] OFS_MGMT_EN4 = 8'h1B;
   localparam logic [7:0] OFS_MGMT_EN5 = 8'h1C;

   // ****************************************
   // Config register fields
   // ****************************************
   localparam int CFG_DIR_BIT = 0;
   localparam int CFG_POL_BIT = 1;
   localparam int CFG_FUNC_LO = 2;
   localparam int CFG_OD_BIT = 7;
   localparam logic [1:0] FUNC_GPIO = 2'h0;
   localparam logic [1:0] FUNC_ALT1 = 2'h1;
   localparam logic [1:0] FUNC_ALT2 = 2'h2;
   localparam logic [1:0] FUNC_ALT3 = 2'h3;
   localparam logic [7:0] CFG_RST_INPUT = 8'h01;
   localparam logic [7:0] CFG_RST_OUT_LOW = 8'h00;
   localparam logic [7:0] CFG_GPIO_OUT = 8'h00;

   // ****************************************
   // Per-pin capabilities
   // ****************************************
   localparam logic [NUM_PINS-1:0] BOTH_EDGE_INTERRUPT_MASK = 14'h300A;
   localparam logic [NUM_PINS-1:0] BOTH_EDGE_INTERRUPT_ALT3_MASK = 14'h0008;
   localparam logic [NUM_PINS-1:0] ANALOG_MASK = 14'h0000;
   localparam logic [NUM_PINS-1:0] RESET_OUT_LOW_MASK = 14'h0080;
   localparam int PIN_GROUP_WAKE = 2;
   localparam int PIN_DRIVE_DENSITY = 3;
   localparam int PIN_IR_TX = 7;
endpackage : gpio_bank_pkg
`default_nettype wire

// ---- gpio_edge_if.sv ----
// Interface carrying synchronised pin levels and edges.
// Assumes one clock shared by producer and consumer.
`timescale 1ns/1ps
`default_nettype none
interface gpio_edge_if;
   logic [15:0] level;
   logic [15:0] rise;
   logic [15:0] fall;
   modport src (output level, output rise, output fall);
   modport dst (input level, input rise, input fall);
endinterface : gpio_edge_if
`default_nettype wire

// ---- pin_sampler.sv ----
// Two-stage synchroniser and edge detector for pins and tach inputs.
// Assumes raw inputs are asynchronous to sys_clk_i.
`timescale 1ns/1ps
`default_nettype none
module pin_sampler
(
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic [15:0] raw_i,
   gpio_edge_if.src edge_o
);
   typedef struct packed
   {
      logic [15:0] s1;
      logic [15:0] s2;
      logic [15:0] prev;
      logic [2:0] fill;
   } samp_state_type;

   samp_state_type st_r;
   samp_state_type st_nxt;

   // ****************************************
   // Next state
   // ****************************************
   // First stage feeds only the second stage
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.s1 = raw_i;
      st_nxt.s2 = st_r.s1;
      st_nxt.prev = st_r.s2;
      st_nxt.fill = {st_r.fill[1:0], 1'b1};
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   // Edges compare the stable stage with its delayed copy
   // Held off until every stage has a real sample, so a high pad makes no false edge after reset
   assign edge_o.level = st_r.s2;
   assign edge_o.rise = st_r.s2 & ~st_r.prev & {16{st_r.fill[2]}};
   assign edge_o.fall = ~st_r.s2 & st_r.prev & {16{st_r.fill[2]}};
endmodule : pin_sampler
`default_nettype wire

// ---- gpio_bank_wake_event_logic.sv ----
// GPIO banks four to six with wake and management-interrupt status logic.
// Assumes host strobes are one-cycle pulses on sys_clk_i; pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Config bit 0 direction, bit 1 polarity, bit 7 open-drain or push-pull.
// - Dir 0 output, dir 1 input; polarity 1 inverts either.
// - Driver type bit applies to GPIO and group interrupt alternate outputs.
// - Polarity inverts alternates too, except drive density, analog, both-edge.
// - Analog joystick alternates become open-drain non-inverted outputs.
// - Input read latches pin level with polarity; input write has no effect.
// - Output drives written bit with polarity; read returns written bit.
// - Output ports never set wake or management status.
// - Polarity picks wake edge; default is rising.
// - Wake event needs status, individual enable and global enable.
// - Writing one clears a wake status bit; zero leaves it.
// - Listed ports raise wake events directly.
// - Wake status bits placed in fourth and fifth status pairs.
// - Listed ports raise management interrupts directly.
// - Management status bits placed in third to fifth pairs.
// - Both-edge ports set misc, wake and management status on any edge.
// - Registers sit at offsets from base held in config 0x60 and 0x61.
// - Bidirectional alternates take their direction from the function.
// - Infrared transmit pin driven low while unused.
// - Bank five bit 3 resets as output driving low.
// - Without main supply that pin reverts to non-inverting GPIO output.
// - Drive density pin resets to the GPIO function.
// - Both-edge function ignores direction, polarity, driver bits on pin; data reads still apply polarity.
// - Data bits latched on host read and host write.
module gpio_bank_wake_event_logic
(
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic cfg_wr_i,
   input wire logic [7:0] cfg_index_i,
   input wire logic [7:0] cfg_wdata_i,
   input wire logic [15:0] io_addr_i,
   input wire logic io_wr_i,
   input wire logic io_rd_i,
   input wire logic [7:0] io_wdata_i,
   output logic [7:0] io_rdata_o,
   output logic [15:0] runtime_block_base_o,
   input wire logic [13:0] pin_i,
   output logic [13:0] pin_o,
   output logic [13:0] pin_oe_n_o,
   input wire logic [13:0] alt_out_i,
   input wire logic [13:0] alt_oe_i,
   input wire logic fan_tachometer_one_i,
   input wire logic fan_tachometer_two_i,
   input wire logic infrared_transmit_idle_i,
   input wire logic vcc_off_i,
   output logic group_wake_o,
   output logic group_mgmt_irq_o
);
   typedef struct packed
   {
      logic [15:0] base;
      logic [13:0][7:0] cfg;
      logic [13:0] data;
      logic glob;
      logic [7:0] wsts4;
      logic [7:0] wsts5;
      logic [7:0] wen4;
      logic [7:0] wen5;
      logic [7:0] msts3;
      logic [7:0] msts4;
      logic [7:0] msts5;
      logic [7:0] men3;
      logic [7:0] men4;
      logic [7:0] men5;
      logic [7:0] misc;
      logic [7:0] rdata;
      logic vcc_s1;
      logic vcc_s2;
   } gpio_state_type;

   // Reset image built at elaboration so reset loads only a constant
   function automatic gpio_state_type reset_state();
      gpio_state_type s;
      s = '0;
      s.base = gpio_bank_pkg::BASE_RESET;
      for (int i = 0; i < gpio_bank_pkg::NUM_PINS; i++)
         s.cfg[i] = gpio_bank_pkg::RESET_OUT_LOW_MASK[i] ? gpio_bank_pkg::CFG_RST_OUT_LOW
                                                          : gpio_bank_pkg::CFG_RST_INPUT;
      return s;
   endfunction : reset_state

   localparam gpio_state_type RST_ST = reset_state();

   gpio_state_type st_r;
   gpio_state_type st_nxt;
   gpio_edge_if eif ();

   logic [13:0][7:0] cfg_eff;
   logic [13:0] both_edge_interrupt_sel;
   logic [13:0] ev;
   logic [13:0] both_ev;
   logic [13:0] rd_bit;
   logic [15:0] off_full;
   logic [7:0] off;
   logic hit;
   logic wr_hit;
   logic rd_hit;
   logic wake_event;

   // ****************************************
   // Pin sampling
   // ****************************************
   pin_sampler u_sampler
   (
      .sys_clk_i (sys_clk_i),
      .sys_rst_i (sys_rst_i),
      .raw_i ({fan_tachometer_two_i, fan_tachometer_one_i, pin_i}),
      .edge_o (eif.src)
   );

   // ****************************************
   // Address decode
   // ****************************************
   // Only offsets within one 256-byte window of the base respond
   assign off_full = io_addr_i - st_r.base;
   assign off = off_full[7:0];
   assign hit = (off_full[15:8] == 8'h00);
   assign wr_hit = io_wr_i && hit;
   assign rd_hit = io_rd_i && hit;

   // ****************************************
   // Per-pin function, drive and events
   // ****************************************
   generate
      for (genvar i = 0; i < gpio_bank_pkg::NUM_PINS; i++)
      begin : g_pin
         logic [1:0] func;
         logic dir;
         logic pol;
         logic alt;
         logic analog;
         logic pol_used;
         logic od_used;
         logic val_raw;
         logic val;
         logic drive;
         logic ir_force;

         // Without main supply the infrared pin falls back to a plain output
         assign cfg_eff[i] = (i == gpio_bank_pkg::PIN_IR_TX && st_r.vcc_s2) ? gpio_bank_pkg::CFG_GPIO_OUT
                                                                           : st_r.cfg[i];
         assign func = cfg_eff[i][gpio_bank_pkg::CFG_FUNC_LO +: 2];
         assign dir = cfg_eff[i][gpio_bank_pkg::CFG_DIR_BIT];
         assign pol = cfg_eff[i][gpio_bank_pkg::CFG_POL_BIT];
         assign alt = (func != gpio_bank_pkg::FUNC_GPIO);
         assign analog = gpio_bank_pkg::ANALOG_MASK[i] && alt;
         assign both_edge_interrupt_sel[i] = gpio_bank_pkg::BOTH_EDGE_INTERRUPT_MASK[i] && (func == (gpio_bank_pkg::BOTH_EDGE_INTERRUPT_ALT3_MASK[i] ?
                              gpio_bank_pkg::FUNC_ALT3 : gpio_bank_pkg::FUNC_ALT2));

         // Drive density and analog alternates bypass the inverter
         assign pol_used = pol && !analog && !(i == gpio_bank_pkg::PIN_DRIVE_DENSITY &&
                           func == gpio_bank_pkg::FUNC_ALT1);
         assign od_used = analog ? 1'b1 : cfg_eff[i][gpio_bank_pkg::CFG_OD_BIT];
         assign val_raw = !alt ? st_r.data[i] :
                          (i == gpio_bank_pkg::PIN_GROUP_WAKE && func == gpio_bank_pkg::FUNC_ALT1) ?
                          wake_event : alt_out_i[i];
         assign val = val_raw ^ pol_used;
         assign ir_force = (i == gpio_bank_pkg::PIN_IR_TX) && infrared_transmit_idle_i;

         // Alternates other than both-edge and analog choose their own direction, so bidirectional lines work
         always_comb
         begin
            if (ir_force)
               drive = 1'b1;
            else if (both_edge_interrupt_sel[i])
               drive = 1'b0;
            else if (analog)
               drive = 1'b1;
            else if (alt)
               drive = alt_oe_i[i];
            else
               drive = !dir;
         end

         // Open drain releases the pin for a one
         assign pin_o[i] = drive && val && !ir_force;
         assign pin_oe_n_o[i] = !(drive && (ir_force || !val || !od_used));

         // Outputs stay out of the status logic; polarity picks the edge
         assign both_ev[i] = both_edge_interrupt_sel[i] && (eif.rise[i] || eif.fall[i]);
         assign ev[i] = both_edge_interrupt_sel[i] ? both_ev[i] :
                        dir ? (pol ? eif.fall[i] : eif.rise[i]) : 1'b0;

         // Inputs read the live level; both-edge pins still honour polarity
         assign rd_bit[i] = (dir || both_edge_interrupt_sel[i]) ? (eif.level[i] ^ pol) : st_r.data[i];
      end
   endgenerate

   // ****************************************
   // Group outputs
   // ****************************************
   assign wake_event = st_r.glob && |((st_r.wsts4 & st_r.wen4) | (st_r.wsts5 & st_r.wen5));
   assign group_wake_o = wake_event;
   assign group_mgmt_irq_o = |((st_r.msts3 & st_r.men3) | (st_r.msts4 & st_r.men4) |
                               (st_r.msts5 & st_r.men5));
   assign io_rdata_o = st_r.rdata;
   assign runtime_block_base_o = st_r.base;

   // ****************************************
   // Next state
   // ****************************************
   // Status set wins over a write-one clear in the same cycle
   always_comb
   begin
      logic [7:0] wclr;
      logic [7:0] w4set;
      logic [7:0] w5set;
      logic [7:0] m3set;
      logic [7:0] m4set;
      logic [7:0] m5set;
      logic [7:0] mset;
      logic [13:0] wr_vec;
      logic [13:0] wr_sel;
      wclr = wr_hit ? io_wdata_i : 8'h00;
      w4set = {ev[13], ev[12], ev[3], ev[1], 4'h0};
      w5set = ev[11:4];
      m3set = {ev[12], 7'h00};
      m4set = {ev[13], ev[3], ev[2], ev[1], 4'h0};
      m5set = {2'h0, eif.rise[gpio_bank_pkg::TACH_TWO_IDX], eif.rise[gpio_bank_pkg::TACH_ONE_IDX],
               ev[11:8]};
      mset = {2'h0, both_ev[13], both_ev[12], both_ev[3], both_ev[1], 2'h0};
      wr_vec = {io_wdata_i[1:0], io_wdata_i, io_wdata_i[3:0]};
      wr_sel = 14'h0000;
      st_nxt = st_r;
      st_nxt.vcc_s1 = vcc_off_i;
      st_nxt.vcc_s2 = st_r.vcc_s1;
      if (cfg_wr_i && cfg_index_i == gpio_bank_pkg::BASE_LO_INDEX)
         st_nxt.base[7:0] = cfg_wdata_i;
      if (cfg_wr_i && cfg_index_i == gpio_bank_pkg::BASE_HI_INDEX)
         st_nxt.base[15:8] = cfg_wdata_i;
      if (wr_hit)
      begin
         unique case (off)
            gpio_bank_pkg::OFS_DATA_BANK4: wr_sel = 14'h000F;
            gpio_bank_pkg::OFS_DATA_BANK5: wr_sel = 14'h0FF0;
            gpio_bank_pkg::OFS_DATA_BANK6: wr_sel = 14'h3000;
            gpio_bank_pkg::OFS_GLOBAL_WAKE: st_nxt.glob = io_wdata_i[0];
            gpio_bank_pkg::OFS_WAKE_EN4: st_nxt.wen4 = io_wdata_i;
            gpio_bank_pkg::OFS_WAKE_EN5: st_nxt.wen5 = io_wdata_i;
            gpio_bank_pkg::OFS_MGMT_EN3: st_nxt.men3 = io_wdata_i;
            gpio_bank_pkg::OFS_MGMT_EN4: st_nxt.men4 = io_wdata_i;
            gpio_bank_pkg::OFS_MGMT_EN5: st_nxt.men5 = io_wdata_i;
            default:
            begin
               for (int i = 0; i < gpio_bank_pkg::NUM_PINS; i++)
                  if (off == gpio_bank_pkg::OFS_CFG_FIRST + 8'(i))
                     st_nxt.cfg[i] = io_wdata_i;
            end
         endcase
      end
      // Only output ports take written data
      for (int i = 0; i < gpio_bank_pkg::NUM_PINS; i++)
         if (wr_sel[i] && !cfg_eff[i][gpio_bank_pkg::CFG_DIR_BIT] && !both_edge_interrupt_sel[i])
            st_nxt.data[i] = wr_vec[i];
      st_nxt.wsts4 = (st_r.wsts4 & ~((off == gpio_bank_pkg::OFS_WAKE_STS4) ? wclr : 8'h00)) | w4set;
      st_nxt.wsts5 = (st_r.wsts5 & ~((off == gpio_bank_pkg::OFS_WAKE_STS5) ? wclr : 8'h00)) | w5set;
      st_nxt.msts3 = (st_r.msts3 & ~((off == gpio_bank_pkg::OFS_MGMT_STS3) ? wclr : 8'h00)) | m3set;
      st_nxt.msts4 = (st_r.msts4 & ~((off == gpio_bank_pkg::OFS_MGMT_STS4) ? wclr : 8'h00)) | m4set;
      st_nxt.msts5 = (st_r.msts5 & ~((off == gpio_bank_pkg::OFS_MGMT_STS5) ? wclr : 8'h00)) | m5set;
      st_nxt.misc = (st_r.misc & ~((off == gpio_bank_pkg::OFS_MISC_STS) ? wclr : 8'h00)) | mset;
      // Read data latched on the read strobe; unmapped reads return zero
      if (rd_hit)
      begin
         unique case (off)
            gpio_bank_pkg::OFS_DATA_BANK4: st_nxt.rdata = {4'h0, rd_bit[3:0]};
            gpio_bank_pkg::OFS_DATA_BANK5: st_nxt.rdata = rd_bit[11:4];
            gpio_bank_pkg::OFS_DATA_BANK6: st_nxt.rdata = {6'h00, rd_bit[13:12]};
            gpio_bank_pkg::OFS_GLOBAL_WAKE: st_nxt.rdata = {7'h00, st_r.glob};
            gpio_bank_pkg::OFS_WAKE_STS4: st_nxt.rdata = st_r.wsts4;
            gpio_bank_pkg::OFS_WAKE_STS5: st_nxt.rdata = st_r.wsts5;
            gpio_bank_pkg::OFS_WAKE_EN4: st_nxt.rdata = st_r.wen4;
            gpio_bank_pkg::OFS_WAKE_EN5: st_nxt.rdata = st_r.wen5;
            gpio_bank_pkg::OFS_MISC_STS: st_nxt.rdata = st_r.misc;
            gpio_bank_pkg::OFS_MGMT_STS3: st_nxt.rdata = st_r.msts3;
            gpio_bank_pkg::OFS_MGMT_STS4: st_nxt.rdata = st_r.msts4;
            gpio_bank_pkg::OFS_MGMT_STS5: st_nxt.rdata = st_r.msts5;
            gpio_bank_pkg::OFS_MGMT_EN3: st_nxt.rdata = st_r.men3;
            gpio_bank_pkg::OFS_MGMT_EN4: st_nxt.rdata = st_r.men4;
            gpio_bank_pkg::OFS_MGMT_EN5: st_nxt.rdata = st_r.men5;
            default:
            begin
               st_nxt.rdata = 8'h00;
               for (int i = 0; i < gpio_bank_pkg::NUM_PINS; i++)
                  if (off == gpio_bank_pkg::OFS_CFG_FIRST + 8'(i))
                     st_nxt.rdata = st_r.cfg[i];
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         st_r <= RST_ST;
      else
         st_r <= st_nxt;
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   rise_sets_wake_a: assert property (st_r.cfg[4][1:0] == 2'b01 && st_r.cfg[4][3:2] == 2'b00
      && eif.rise[4] |=> st_r.wsts5[0]) else $error("rising input edge missed wake status");
   output_no_status_a: assert property (!st_r.cfg[7][0] && !st_r.wsts5[3] ##1 !st_r.cfg[7][0]
      |-> !st_r.wsts5[3]) else $error("output port set wake status");
   wake_clear_a: assert property (wr_hit && off == gpio_bank_pkg::OFS_WAKE_STS5 && io_wdata_i[0]
      && !ev[4] |=> !st_r.wsts5[0]) else $error("write one did not clear status");
   wake_gate_a: assert property (!st_r.glob |-> !group_wake_o) else $error("wake without global enable");
   output_drive_a: assert property (st_r.cfg[7] == 8'h02 && !st_r.vcc_s2 && !infrared_transmit_idle_i
      |-> !pin_oe_n_o[7] && pin_o[7] == !st_r.data[7]) else $error("inverted output wrong");
   input_read_a: assert property (rd_hit && off == gpio_bank_pkg::OFS_DATA_BANK5
      && st_r.cfg[4][1:0] == 2'b11 |=> io_rdata_o[0] == !$past(eif.level[4])) else $error("input read not latched");
   both_edge_interrupt_fall_a: assert property (both_edge_interrupt_sel[1] && eif.fall[1] |=> st_r.misc[2] && st_r.wsts4[4])
      else $error("both-edge fall missed");
   ir_low_a: assert property (infrared_transmit_idle_i |-> !pin_o[7] && !pin_oe_n_o[7])
      else $error("idle infrared pin not low");
   vcc_off_a: assert property (st_r.vcc_s2 && !infrared_transmit_idle_i
      |-> !pin_oe_n_o[7] && pin_o[7] == st_r.data[7]) else $error("no-supply fallback wrong");

   wake_seen_c: cover property (group_wake_o);
   mgmt_seen_c: cover property (group_mgmt_irq_o);
   both_edge_interrupt_seen_c: cover property (|both_ev);
endmodule : gpio_bank_wake_event_logic
`default_nettype wire

// ---- pin_partner.sv ----
// Far-side model: external drivers on the bank pads.
// Assumes active-low output enables from the bank.
`timescale 1ns/1ps
`default_nettype none
module pin_partner
(
   input wire logic [13:0] pin_i,
   input wire logic [13:0] pin_oe_n_i,
   input wire logic [13:0] ext_i,
   output logic [13:0] pad_o
);
   // Bank wins where it drives, else the outside level shows
   always_comb
   begin
      for (int i = 0; i < 14; i++)
         pad_o[i] = pin_oe_n_i[i] ? ext_i[i] : pin_i[i];
   end
endmodule : pin_partner
`default_nettype wire

// ---- gpio_bank_wake_event_logic_tb.sv ----
// Self-checking bench for the GPIO bank: host strobes, pads, wake logic.
// Assumes the pin_partner model resolves the pads.
`timescale 1ns/1ps
`default_nettype none
module gpio_bank_wake_event_logic_tb;
   logic sys_clk_i, sys_rst_i, cfg_wr_i, io_wr_i, io_rd_i, ir_idle, rd_seen, group_wake_o;
   logic vcc_off, tach, group_mgmt_irq_o;
   logic [7:0] cfg_index_i, cfg_wdata_i, io_wdata_i, io_rdata_o;
   logic [15:0] io_addr_i, base, runtime_block_base_o;
   logic [13:0] pad, ext, pin_o, pin_oe_n_o;
   logic [7:0] exp_q[$];
   int n_fail = 0;
   int total_checks = 0;
   // ****************************************
   // Design and far side
   // ****************************************
   gpio_bank_wake_event_logic dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .cfg_wr_i(cfg_wr_i),
      .cfg_index_i(cfg_index_i), .cfg_wdata_i(cfg_wdata_i), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i),
      .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
      .runtime_block_base_o(runtime_block_base_o), .pin_i(pad), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o),
      .alt_out_i(14'h0000), .alt_oe_i(14'h0000), .fan_tachometer_one_i(tach), .fan_tachometer_two_i(1'b0),
      .infrared_transmit_idle_i(ir_idle), .vcc_off_i(vcc_off), .group_wake_o(group_wake_o),
      .group_mgmt_irq_o(group_mgmt_irq_o));
   pin_partner partner (.pin_i(pin_o), .pin_oe_n_i(pin_oe_n_o), .ext_i(ext), .pad_o(pad));
   // 20 MHz clock
   initial
   begin
      sys_clk_i = 1'b0;
      forever #25 sys_clk_i = ~sys_clk_i;
   end
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic cfg(input logic [7:0] idx, input logic [7:0] val);
      @(negedge sys_clk_i);
      cfg_wr_i = 1'b1;
      cfg_index_i = idx;
      cfg_wdata_i = val;
      @(negedge sys_clk_i);
      cfg_wr_i = 1'b0;
   endtask : cfg
   // Read notes its expectation; the monitor compares a cycle later
   task automatic io(input logic rd, input logic [7:0] ofs, input logic [7:0] val);
      @(negedge sys_clk_i);
      io_addr_i = base + {8'h00, ofs};
      io_wdata_i = val;
      if (rd)
      begin
         io_rd_i = 1'b1;
         exp_q.push_back(val);
      end
      else
         io_wr_i = 1'b1;
      @(negedge sys_clk_i);
      io_rd_i = 1'b0;
      io_wr_i = 1'b0;
   endtask : io
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_of_test
   // Read data stands the cycle after the strobe
   always @(posedge sys_clk_i) rd_seen <= io_rd_i;
   always @(negedge sys_clk_i)
      if (rd_seen) chk("io_rdata_o", {8'h00, exp_q.pop_front()}, {8'h00, io_rdata_o});
   // Watchdog well past the roughly 120 cycles the tests need
   initial
   begin
      repeat (3000) @(posedge sys_clk_i);
      n_fail++;
      end_of_test();
   end
   // ****************************************
   // Tests
   // ****************************************
   initial
   begin
      {sys_rst_i, cfg_wr_i, io_wr_i, io_rd_i, ir_idle, vcc_off, tach} = 7'h40;
      {cfg_index_i, cfg_wdata_i, io_wdata_i, io_addr_i} = 40'h0;
      void'($urandom(32'hC1E06764));
      ext = 14'($urandom);
      base = 16'($urandom) & 16'hFF00;
      repeat (16) @(posedge sys_clk_i);
      @(negedge sys_clk_i) sys_rst_i = 1'b0;
      chk("pin_oe_n_o", 16'h3F7F, {2'b00, pin_oe_n_o});
      chk("pin_o", 16'h0000, {15'h0000, pin_o[7]});
      cfg(gpio_bank_pkg::BASE_LO_INDEX, base[7:0]);
      cfg(gpio_bank_pkg::BASE_HI_INDEX, base[15:8]);
      cfg(8'h62, 8'hFF);
      chk("runtime_block_base_o", base, runtime_block_base_o);
      repeat (4) @(negedge sys_clk_i);
      io(1'b0, gpio_bank_pkg::OFS_WAKE_STS5, 8'hFF);
      $display("test reset and base done");
      // Inputs read the pads, pin 7 is a low output after reset
      io(1'b1, gpio_bank_pkg::OFS_DATA_BANK4, {4'h0, ext[3:0]});
      io(1'b1, gpio_bank_pkg::OFS_DATA_BANK5, {ext[11:8], 1'b0, ext[6:4]});
      io(1'b1, gpio_bank_pkg::OFS_DATA_BANK6, {6'h00, ext[13:12]});
      io(1'b1, 8'h02, 8'h00);
      io(1'b0, gpio_bank_pkg::OFS_CFG_FIRST + 8'h04, 8'h03);
      io(1'b1, gpio_bank_pkg::OFS_DATA_BANK5, {ext[11:8], 1'b0, ext[6:5], ~ext[4]});
      $display("test inputs done");
      // Output drive, forced-low infrared pin, inverted output
      io(1'b0, gpio_bank_pkg::OFS_DATA_BANK5, 8'h08);
      chk("pin_o", 16'h0001, {15'h0000, pin_o[7]});
      chk("pin_oe_n_o", 16'h0000, {15'h0000, pin_oe_n_o[7]});
      ir_idle = 1'b1;
      @(negedge sys_clk_i);
      chk("pin_o", 16'h0000, {15'h0000, pin_o[7]});
      ir_idle = 1'b0;
      io(1'b0, gpio_bank_pkg::OFS_CFG_FIRST + 8'h07, 8'h02);
      chk("pin_o", 16'h0000, {15'h0000, pin_o[7]});
      io(1'b1, gpio_bank_pkg::OFS_DATA_BANK5, {ext[11:8], 1'b1, ext[6:5], ~ext[4]});
      repeat (4) @(negedge sys_clk_i);
      io(1'b1, gpio_bank_pkg::OFS_WAKE_STS5, 8'h00);
      $display("test outputs done");
      // Wake event on pin 4 with gating and write-one clear
      ext[4] = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      io(1'b0, gpio_bank_pkg::OFS_WAKE_STS5, 8'h01);
      io(1'b0, gpio_bank_pkg::OFS_WAKE_EN5, 8'h01);
      ext[4] = 1'b0;
      repeat (4) @(negedge sys_clk_i);
      chk("group_wake_o", 16'h0000, {15'h0000, group_wake_o});
      io(1'b1, gpio_bank_pkg::OFS_WAKE_STS5, 8'h01);
      io(1'b0, gpio_bank_pkg::OFS_GLOBAL_WAKE, 8'h01);
      chk("group_wake_o", 16'h0001, {15'h0000, group_wake_o});
      io(1'b0, gpio_bank_pkg::OFS_WAKE_STS5, 8'h00);
      chk("group_wake_o", 16'h0001, {15'h0000, group_wake_o});
      io(1'b0, gpio_bank_pkg::OFS_WAKE_STS5, 8'h01);
      chk("group_wake_o", 16'h0000, {15'h0000, group_wake_o});
      io(1'b0, gpio_bank_pkg::OFS_CFG_FIRST + 8'h04, 8'h01);
      ext[4] = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      io(1'b1, gpio_bank_pkg::OFS_WAKE_STS5, 8'h01);
      $display("test wake done");
      // Both-edge pin 1: each pad edge sets misc, wake and management status
      io(1'b0, gpio_bank_pkg::OFS_CFG_FIRST + 8'h01, 8'h08);
      io(1'b0, gpio_bank_pkg::OFS_MGMT_EN4, 8'h10);
      ext[1] = ~ext[1];
      repeat (4) @(negedge sys_clk_i);
      chk("group_mgmt_irq_o", 16'h0001, {15'h0000, group_mgmt_irq_o});
      io(1'b1, gpio_bank_pkg::OFS_MISC_STS, 8'h04);
      io(1'b1, gpio_bank_pkg::OFS_MGMT_STS4, 8'h10);
      io(1'b1, gpio_bank_pkg::OFS_WAKE_STS4, 8'h10);
      io(1'b0, gpio_bank_pkg::OFS_MISC_STS, 8'h04);
      io(1'b0, gpio_bank_pkg::OFS_MGMT_STS4, 8'h10);
      chk("group_mgmt_irq_o", 16'h0000, {15'h0000, group_mgmt_irq_o});
      ext[1] = ~ext[1];
      repeat (4) @(negedge sys_clk_i);
      chk("group_mgmt_irq_o", 16'h0001, {15'h0000, group_mgmt_irq_o});
      io(1'b1, gpio_bank_pkg::OFS_MISC_STS, 8'h04);
      // Tachometer rising edge and supply loss on the infrared pin
      tach = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      io(1'b1, gpio_bank_pkg::OFS_MGMT_STS5, 8'h10);
      vcc_off = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      chk("pin_o", 16'h0001, {15'h0000, pin_o[7]});
      chk("pin_oe_n_o", 16'h0000, {15'h0000, pin_oe_n_o[7]});
      $display("test both-edge, tach and supply done");
      repeat (2) @(negedge sys_clk_i);
      end_of_test();
   end
endmodule : gpio_bank_wake_event_logic_tb
`default_nettype wire
